//--- rtl/rcd_decoder.sv
// receiver command decoder: command packets in, reports and receiver state out
//
// Operation
// - clear-backup reads mode byte, erases, resets
// - mode 0x4b erases backed memory only
// - mode 0x46 erases backed memory and flash
// - version request answers version report
// - time request answers time report
// - cartesian position is X, Y, Z words
// - initial positions ignored while fixing
// - fix-mode and signal requests answer reports
// - soft reset with self-test, start-up messages
// - version report unprompted only after reset
// - health request answers health then machine
// - four-byte altitude command stores reference altitude
// - manual 2D uses reference or held altitude
// - empty altitude command answers nine-byte position
// - geodetic position is latitude, longitude, altitude
// - oscillator request answers oscillator report
// - set-time is week seconds, week; answered
// - set-time ignored once time known
// - week zero epoch, seconds from Sunday
// - signal mask with hysteresis, default 3
// - no fix above DOP mask, switch auto
// - auto tries 3D below switch, then 2D
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "rcd_consts.svh"
module rcd_decoder
    import rcd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire rcd_rx_type rx,
    output logic rx_ready,
    output rcd_rpt_type rpt,
    output rcd_pos_type init_pos,
    output rcd_time_type time_set,
    output rcd_reset_type rst_ctl,
    input wire logic fixing,
    input wire logic time_known,
    input wire logic [31:0] last_3d_alt,
    output logic [31:0] alt_used,
    input wire logic [`RCD_NCH-1:0] sig_lock,
    input wire logic [`RCD_NCH-1:0][7:0] sig_level,
    output logic [`RCD_NCH-1:0] sig_used,
    input wire logic sol_valid,
    input wire logic [7:0] pdop_3d,
    input wire logic [7:0] dop_2d,
    output logic [1:0] fix_sel,
    output logic fix_dec,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    localparam rcd_state_type STATE_RST = '{phase: PH_BOOT, fix_mode: `RCD_FIX_MODE_RST,
        sig_mask: `RCD_SIG_MASK_RST, dop_mask: `RCD_DOP_MASK_RST, dop_switch: `RCD_DOP_SWITCH_RST, default: '0};

    rcd_state_type s_reg;
    rcd_state_type s_next;
    logic take;
    logic end_pkt;
    logic [7:0] cmd_c;
    logic [3:0] cnt_c;
    logic [95:0] data_c;
    logic [8:0] sig_hi;
    logic [8:0] sig_lo;
    logic [`RCD_NCH-1:0] sig_used_c;

    // packet assembly: first byte is the code, the rest shift in
    always_comb begin
        take = rx.valid && s_reg.rx_ready;
        end_pkt = take && rx.last;
        cmd_c = s_reg.cmd;
        cnt_c = s_reg.cnt;
        data_c = s_reg.data;
        if (take && rx.first) begin
            cmd_c = rx.data;
            cnt_c = `RCD_LEN_NONE;
        end else if (take) begin
            data_c = {s_reg.data[87:0], rx.data};
            cnt_c = (s_reg.cnt == `RCD_LEN_MAX) ? s_reg.cnt : s_reg.cnt + 4'h1; // overlong sticks
        end
    end

    // hysteresis window around the signal mask
    always_comb begin
        sig_hi = {1'b0, s_reg.sig_mask} + {1'b0, `RCD_SIG_HYST};
        sig_lo = (s_reg.sig_mask >= `RCD_SIG_HYST) ? {1'b0, s_reg.sig_mask - `RCD_SIG_HYST} : 9'h000;
    end

    // per channel: keep while at or above low edge, admit at or above high edge
    genvar g;
    generate
        for (g = 0; g < `RCD_NCH; g = g + 1) begin : g_ch
            assign sig_used_c[g] = sig_lock[g] && (s_reg.sig_used[g] ? ({1'b0, sig_level[g]} >= sig_lo) :
                ({1'b0, sig_level[g]} >= sig_hi));
        end
    endgenerate

    // next state
    always_comb begin
        s_next = s_reg;
        s_next.rpt = '0;
        s_next.rst_ctl = '0;
        s_next.pos.valid = 1'b0;
        s_next.tim.valid = 1'b0;
        s_next.fix_dec = 1'b0;
        s_next.rdata = 32'h00000000;
        s_next.cmd = cmd_c;
        s_next.cnt = cnt_c;
        s_next.data = data_c;
        s_next.sig_used = sig_used_c;
        // register writes
        if (wr) begin
            case (addr)
                `RCD_ADDR_FIX_MODE: s_next.fix_mode = wdata[1:0];
                `RCD_ADDR_SIG_MASK: s_next.sig_mask = wdata[7:0];
                `RCD_ADDR_DOP_MASK: s_next.dop_mask = wdata[7:0];
                `RCD_ADDR_DOP_SWITCH: s_next.dop_switch = wdata[7:0];
                default: ;
            endcase
        end
        // register reads, data in the following cycle only
        if (rd) begin
            case (addr)
                `RCD_ADDR_FIX_MODE: s_next.rdata = {30'h00000000, s_reg.fix_mode};
                `RCD_ADDR_SIG_MASK: s_next.rdata = {24'h000000, s_reg.sig_mask};
                `RCD_ADDR_DOP_MASK: s_next.rdata = {24'h000000, s_reg.dop_mask};
                `RCD_ADDR_DOP_SWITCH: s_next.rdata = {24'h000000, s_reg.dop_switch};
                `RCD_ADDR_STATUS: s_next.rdata = {16'h0000, s_reg.sig_used, 1'b0, s_reg.alt_flag,
                    s_reg.fix_sel, s_reg.fix_mode, s_reg.phase};
                `RCD_ADDR_REF_ALT: s_next.rdata = s_reg.ref_alt;
                `RCD_ADDR_ALT_USED: s_next.rdata = s_reg.alt_used;
                default: s_next.rdata = 32'h00000000;
            endcase
        end
        // altitude for manual 2D: reference if flagged, else held 3D
        if (s_reg.fix_mode == `RCD_FIX_MAN2D && s_reg.alt_flag) begin
            s_next.alt_used = s_reg.ref_alt;
        end else begin
            s_next.alt_used = last_3d_alt;
        end
        // fix choice against mask and switch
        if (sol_valid) begin
            s_next.fix_dec = 1'b1;
            case (s_reg.fix_mode)
                `RCD_FIX_AUTO: begin
                    if (pdop_3d < s_reg.dop_switch && pdop_3d < s_reg.dop_mask) begin
                        s_next.fix_sel = `RCD_SEL_3D;
                    end else if (dop_2d < s_reg.dop_mask) begin
                        s_next.fix_sel = `RCD_SEL_2D;
                    end else begin
                        s_next.fix_sel = `RCD_SEL_NONE;
                    end
                end
                `RCD_FIX_MAN3D: s_next.fix_sel = (pdop_3d < s_reg.dop_mask) ? `RCD_SEL_3D : `RCD_SEL_NONE;
                `RCD_FIX_MAN2D: s_next.fix_sel = (dop_2d < s_reg.dop_mask) ? `RCD_SEL_2D : `RCD_SEL_NONE;
                default: s_next.fix_sel = `RCD_SEL_NONE;
            endcase
        end
        // start-up messages and command decode
        case (s_reg.phase)
            PH_BOOT: begin
                s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_VERSION, nine_byte: 1'b0};
                s_next.phase = PH_HEALTH_A;
            end
            PH_HEALTH_A: begin
                s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_HEALTH, nine_byte: 1'b0};
                s_next.phase = PH_HEALTH_B;
            end
            PH_HEALTH_B: begin
                s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_MACHINE, nine_byte: 1'b0};
                s_next.phase = PH_RUN;
            end
            PH_RUN: begin
                if (end_pkt) begin
                    // lengths that fit no form fall through without answer
                    case (cmd_c)
                        `RCD_CMD_CLEAR_BACKUP: begin
                            if (cnt_c == `RCD_LEN_ONE && (data_c[7:0] == `RCD_MODE_COLD ||
                                data_c[7:0] == `RCD_MODE_FACTORY)) begin
                                s_next.rst_ctl.erase_bbm = 1'b1;
                                s_next.rst_ctl.erase_flash = (data_c[7:0] == `RCD_MODE_FACTORY);
                                s_next.rst_ctl.soft_reset = 1'b1;
                                s_next.rst_ctl.self_test = 1'b1;
                                s_next.ref_alt = 32'h00000000;
                                s_next.alt_flag = 1'b0;
                                s_next.fix_mode = `RCD_FIX_MODE_RST;
                                s_next.sig_mask = `RCD_SIG_MASK_RST;
                                s_next.dop_mask = `RCD_DOP_MASK_RST;
                                s_next.dop_switch = `RCD_DOP_SWITCH_RST;
                                s_next.phase = PH_BOOT;
                            end
                        end
                        `RCD_CMD_VERSION: if (cnt_c == `RCD_LEN_NONE) begin
                            s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_VERSION, nine_byte: 1'b0};
                        end
                        `RCD_CMD_TIME: if (cnt_c == `RCD_LEN_NONE) begin
                            s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_TIME, nine_byte: 1'b0};
                        end
                        `RCD_CMD_POS_XYZ, `RCD_CMD_POS_LLA: begin
                            if (cnt_c == `RCD_LEN_POS && !fixing) begin
                                // words in send order: X,Y,Z or lat,lon,alt
                                s_next.pos.a = data_c[95:64];
                                s_next.pos.b = data_c[63:32];
                                s_next.pos.c = data_c[31:0];
                                s_next.pos.geodetic = (cmd_c == `RCD_CMD_POS_LLA);
                                s_next.pos.valid = 1'b1;
                            end
                        end
                        `RCD_CMD_FIX_MODE: if (cnt_c == `RCD_LEN_NONE) begin
                            s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_ALL_IN_VIEW, nine_byte: 1'b0};
                        end
                        `RCD_CMD_SIG_LEVEL: if (cnt_c == `RCD_LEN_NONE) begin
                            s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_SIG_LEVEL, nine_byte: 1'b0};
                        end
                        `RCD_CMD_SOFT_RESET: if (cnt_c == `RCD_LEN_NONE) begin
                            s_next.rst_ctl.soft_reset = 1'b1;
                            s_next.rst_ctl.self_test = 1'b1;
                            s_next.phase = PH_BOOT;
                        end
                        `RCD_CMD_HEALTH: if (cnt_c == `RCD_LEN_NONE) begin
                            s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_HEALTH, nine_byte: 1'b0};
                            s_next.phase = PH_HEALTH_B;
                        end
                        `RCD_CMD_ALT: begin
                            if (cnt_c == `RCD_LEN_NONE) begin
                                s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_LLA, nine_byte: 1'b1};
                            end else if (cnt_c == `RCD_LEN_ALT) begin
                                s_next.ref_alt = data_c[31:0];
                                s_next.alt_flag = 1'b1;
                                s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_LLA, nine_byte: 1'b1};
                            end else if (cnt_c == `RCD_LEN_ONE && data_c[7:0] == `RCD_ALT_CLEAR) begin
                                s_next.alt_flag = 1'b0;
                                s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_LLA, nine_byte: 1'b1};
                            end
                        end
                        `RCD_CMD_OSC: if (cnt_c == `RCD_LEN_NONE) begin
                            s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_OSC, nine_byte: 1'b0};
                        end
                        `RCD_CMD_SET_TIME: if (cnt_c == `RCD_LEN_TIME) begin
                            s_next.rpt = '{valid: 1'b1, id: `RCD_RPT_TIME_SET, nine_byte: 1'b0};
                            if (!time_known) begin
                                // week from the 1980 epoch, seconds from Sunday midnight, kept as sent
                                s_next.tim.tow = data_c[47:16];
                                s_next.tim.week = data_c[15:0];
                                s_next.tim.valid = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            default: s_next.phase = PH_RUN;
        endcase
        s_next.rx_ready = (s_next.phase == PH_RUN); // stall input during start-up and health pair
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign rx_ready = s_reg.rx_ready;
    assign rpt = s_reg.rpt;
    assign init_pos = s_reg.pos;
    assign time_set = s_reg.tim;
    assign rst_ctl = s_reg.rst_ctl;
    assign alt_used = s_reg.alt_used;
    assign sig_used = s_reg.sig_used;
    assign fix_sel = s_reg.fix_sel;
    assign fix_dec = s_reg.fix_dec;
    assign rdata = s_reg.rdata;

    // checks
    boot_version_a: assert property (@(posedge clk) $fell(srst) |=>
        rpt.valid && rpt.id == `RCD_RPT_VERSION ##1 rpt.id == `RCD_RPT_HEALTH ##1 rpt.id == `RCD_RPT_MACHINE)
        else $error("start-up report order wrong");
    health_pair_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_HEALTH && cnt_c == `RCD_LEN_NONE |=>
        rpt.id == `RCD_RPT_HEALTH && !rx_ready ##1 rpt.valid && rpt.id == `RCD_RPT_MACHINE ##1 rx_ready)
        else $error("health pair wrong");
    cold_start_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_CLEAR_BACKUP && cnt_c == `RCD_LEN_ONE &&
        data_c[7:0] == `RCD_MODE_COLD |=> rst_ctl.erase_bbm && !rst_ctl.erase_flash && rst_ctl.soft_reset)
        else $error("cold start wrong");
    factory_reset_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_CLEAR_BACKUP && cnt_c == `RCD_LEN_ONE &&
        data_c[7:0] == `RCD_MODE_FACTORY |=> rst_ctl.erase_bbm && rst_ctl.erase_flash ##1 rpt.id == `RCD_RPT_VERSION)
        else $error("factory reset wrong");
    pos_ignore_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && (cmd_c == `RCD_CMD_POS_XYZ || cmd_c == `RCD_CMD_POS_LLA) && fixing |=> !init_pos.valid)
        else $error("position taken while fixing");
    pos_words_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_POS_XYZ && cnt_c == `RCD_LEN_POS && !fixing |=>
        init_pos.valid && !init_pos.geodetic && init_pos.a == $past(data_c[95:64]) &&
        init_pos.c == $past(data_c[31:0]))
        else $error("position words wrong");
    time_ignore_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_SET_TIME && cnt_c == `RCD_LEN_TIME &&
        time_known |=> !time_set.valid && rpt.id == `RCD_RPT_TIME_SET && $stable(time_set.week))
        else $error("time changed once known");
    alt_store_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_ALT && cnt_c == `RCD_LEN_ALT |=>
        s_reg.alt_flag && s_reg.ref_alt == $past(data_c[31:0]) && rpt.nine_byte)
        else $error("altitude not stored");
    bad_len_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_VERSION && cnt_c != `RCD_LEN_NONE |=> !rpt.valid)
        else $error("bad length answered");
    sig_admit_a: assert property (@(posedge clk) disable iff (srst)
        $rose(sig_used[0]) |-> {1'b0, $past(sig_level[0])} >= $past(sig_hi))
        else $error("signal admitted below window");
    dop_mask_a: assert property (@(posedge clk) disable iff (srst)
        fix_dec && fix_sel == `RCD_SEL_3D |-> $past(pdop_3d) < $past(s_reg.dop_mask))
        else $error("fix above dop mask");
    soft_reset_c: cover property (@(posedge clk) disable iff (srst) rst_ctl.soft_reset ##3 rx_ready);
    fix_2d_c: cover property (@(posedge clk) disable iff (srst) fix_dec && fix_sel == `RCD_SEL_2D);
    drop_c: cover property (@(posedge clk) disable iff (srst) $fell(sig_used[0]) && sig_lock[0]);
    alt_query_c: cover property (@(posedge clk) disable iff (srst) rpt.valid && rpt.nine_byte);
    pos_take_c: cover property (@(posedge clk) disable iff (srst) init_pos.valid && init_pos.geodetic);
    // time words, altitude flag, altitude choice and hysteresis drop
    time_take_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_SET_TIME && cnt_c == `RCD_LEN_TIME && !time_known |=>
        time_set.valid && time_set.tow == $past(data_c[47:16]) && time_set.week == $past(data_c[15:0]))
        else $error("time words wrong");
    alt_clear_a: assert property (@(posedge clk) disable iff (srst)
        end_pkt && s_reg.phase == PH_RUN && cmd_c == `RCD_CMD_ALT && cnt_c == `RCD_LEN_ONE &&
        data_c[7:0] == `RCD_ALT_CLEAR |=> !s_reg.alt_flag && rpt.valid && rpt.nine_byte)
        else $error("altitude flag not cleared");
    alt_pick_a: assert property (@(posedge clk) disable iff (srst)
        $past(s_reg.fix_mode) == `RCD_FIX_MAN2D && $past(s_reg.alt_flag) |-> alt_used == $past(s_reg.ref_alt))
        else $error("reference altitude not used");
    sig_drop_a: assert property (@(posedge clk) disable iff (srst)
        $fell(sig_used[0]) |-> !$past(sig_lock[0]) || {1'b0, $past(sig_level[0])} < $past(sig_lo))
        else $error("signal dropped inside window");
endmodule

//--- rtl/rcd_consts.svh
// constants of the receiver command decoder
`ifndef RCD_CONSTS_SVH
`define RCD_CONSTS_SVH
`define RCD_NCH 8
`define RCD_CMD_CLEAR_BACKUP 8'h1e
`define RCD_CMD_VERSION 8'h1f
`define RCD_CMD_TIME 8'h21
`define RCD_CMD_POS_XYZ 8'h23
`define RCD_CMD_FIX_MODE 8'h24
`define RCD_CMD_SOFT_RESET 8'h25
`define RCD_CMD_HEALTH 8'h26
`define RCD_CMD_SIG_LEVEL 8'h27
`define RCD_CMD_ALT 8'h2a
`define RCD_CMD_POS_LLA 8'h2b
`define RCD_CMD_OSC 8'h2d
`define RCD_CMD_SET_TIME 8'h2e
`define RCD_RPT_TIME 8'h41
`define RCD_RPT_VERSION 8'h45
`define RCD_RPT_HEALTH 8'h46
`define RCD_RPT_SIG_LEVEL 8'h47
`define RCD_RPT_LLA 8'h4a
`define RCD_RPT_MACHINE 8'h4b
`define RCD_RPT_OSC 8'h4d
`define RCD_RPT_TIME_SET 8'h4e
`define RCD_RPT_ALL_IN_VIEW 8'h6d
`define RCD_MODE_COLD 8'h4b
`define RCD_MODE_FACTORY 8'h46
`define RCD_ALT_CLEAR 8'hff
`define RCD_LEN_NONE 4'h0
`define RCD_LEN_ONE 4'h1
`define RCD_LEN_ALT 4'h4
`define RCD_LEN_TIME 4'h6
`define RCD_LEN_POS 4'hc
`define RCD_LEN_MAX 4'hd
`define RCD_ADDR_FIX_MODE 8'h00
`define RCD_ADDR_SIG_MASK 8'h04
`define RCD_ADDR_DOP_MASK 8'h08
`define RCD_ADDR_DOP_SWITCH 8'h0c
`define RCD_ADDR_STATUS 8'h10
`define RCD_ADDR_REF_ALT 8'h14
`define RCD_ADDR_ALT_USED 8'h18
`define RCD_FIX_AUTO 2'h0
`define RCD_FIX_MAN2D 2'h1
`define RCD_FIX_MAN3D 2'h2
`define RCD_SEL_NONE 2'h0
`define RCD_SEL_2D 2'h1
`define RCD_SEL_3D 2'h2
`define RCD_FIX_MODE_RST 2'h0
`define RCD_SIG_MASK_RST 8'h03
`define RCD_SIG_HYST 8'h01
`define RCD_DOP_MASK_RST 8'h78
`define RCD_DOP_SWITCH_RST 8'h3c
`endif

//--- rtl/rcd_pkg.sv
// types of the receiver command decoder
package rcd_pkg;
`include "rcd_consts.svh"
    typedef enum logic [1:0] {PH_BOOT, PH_HEALTH_A, PH_HEALTH_B, PH_RUN} rcd_phase_type;
    typedef struct packed {logic valid; logic first; logic last; logic [7:0] data;} rcd_rx_type;
    typedef struct packed {logic valid; logic [7:0] id; logic nine_byte;} rcd_rpt_type;
    typedef struct packed {logic [31:0] a; logic [31:0] b; logic [31:0] c; logic geodetic; logic valid;} rcd_pos_type;
    typedef struct packed {logic [31:0] tow; logic [15:0] week; logic valid;} rcd_time_type;
    typedef struct packed {logic erase_bbm; logic erase_flash; logic soft_reset; logic self_test;} rcd_reset_type;
    typedef struct packed {
        rcd_phase_type phase;
        logic rx_ready;
        logic [7:0] cmd;
        logic [3:0] cnt;
        logic [95:0] data;
        rcd_rpt_type rpt;
        rcd_pos_type pos;
        rcd_time_type tim;
        rcd_reset_type rst_ctl;
        logic [31:0] ref_alt;
        logic alt_flag;
        logic [31:0] alt_used;
        logic [1:0] fix_mode;
        logic [7:0] sig_mask;
        logic [7:0] dop_mask;
        logic [7:0] dop_switch;
        logic [`RCD_NCH-1:0] sig_used;
        logic [1:0] fix_sel;
        logic fix_dec;
        logic [31:0] rdata;
    } rcd_state_type;
endpackage

//--- tb/rcd_host_model.sv
// host side model: feeds command packets one byte per cycle, one byte every other cycle when slow
`timescale 1ns/1ns
module rcd_host_model
    import rcd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic rx_ready,
    input wire logic slow,
    output rcd_rx_type rx
);
    logic [9:0] q[$];
    logic gap;
    initial begin
        rx = '0;
        gap = 1'b0;
    end
    // code byte first, then data bytes, msb of the first word leading
    task put(input logic [7:0] c, input logic [3:0] n, input logic [95:0] p);
        q.push_back({1'b1, n == 4'h0, c});
        for (int i = 0; i < n; i++) begin
            q.push_back({1'b0, i == n - 1, i < 12 ? p[95 - 8 * i -: 8] : 8'h00});
        end
    endtask
    // hold a byte until taken; idle data toggles so nothing stale looks valid
    always @(posedge clk) begin
        if (srst) begin
            rx.valid <= 1'b0;
        end else if (rx.valid && !rx_ready) begin
            rx <= rx;
        end else if (q.size() > 0 && !(slow && !gap)) begin
            rx <= {1'b1, q.pop_front()};
            gap <= 1'b0;
        end else begin
            rx <= {3'b000, ~rx.data};
            gap <= 1'b1;
        end
    end
endmodule

//--- tb/rcd_decoder_tb.sv
// self-checking bench of the receiver command decoder
`timescale 1ns/1ns
module rcd_decoder_tb
    import rcd_pkg::*;
;
    logic clk, srst, fixing, time_known, sol_valid, wr, rd, slow, rx_ready, fix_dec;
    logic [31:0] last_3d_alt, wdata, alt_used, rdata;
    logic [7:0] pdop_3d, dop_2d, addr, sig_lock, sig_used;
    logic [7:0][7:0] sig_level;
    logic [1:0] fix_sel;
    rcd_rx_type rx;
    rcd_rpt_type rpt;
    rcd_pos_type init_pos, pos_seen;
    rcd_time_type time_set, time_seen;
    rcd_reset_type rst_ctl, rst_seen;
    logic [26:0] rs;
    int ev, err_count, checks_done, k;
    // code, data count, expected report trail
    logic [38:0] rows [12] = '{{8'h1f, 4'h0, 27'h08a}, {8'h21, 4'h0, 27'h082}, {8'h24, 4'h0, 27'h0da},
        {8'h27, 4'h0, 27'h08e}, {8'h2d, 4'h0, 27'h09a}, {8'h2a, 4'h0, 27'h095}, {8'h26, 4'h0, 27'h11896},
        {8'h1f, 4'h1, 27'h0}, {8'h2e, 4'h5, 27'h0}, {8'h1e, 4'h1, 27'h0}, {8'h2a, 4'h1, 27'h0}, {8'h23, 4'hd, 27'h0}};
    // fix mode, pdop, 2d dop, expected selection
    logic [19:0] fx [7] = '{{2'h0, 8'h3b, 8'h90, 2'h2}, {2'h0, 8'h3c, 8'h77, 2'h1}, {2'h0, 8'h50, 8'h78, 2'h0},
        {2'h2, 8'h50, 8'h90, 2'h2}, {2'h2, 8'h78, 8'h10, 2'h0}, {2'h1, 8'h10, 8'h77, 2'h1}, {2'h1, 8'h10, 8'h78, 2'h0}};
    // code, count, mode byte, expected reset pulses
    logic [23:0] rr [3] = '{{8'h1e, 4'h1, 8'h4b, 4'hb}, {8'h1e, 4'h1, 8'h46, 4'hf}, {8'h25, 4'h0, 8'h00, 4'h3}};
    rcd_decoder u_dut (.clk, .srst, .rx, .rx_ready, .rpt, .init_pos, .time_set, .rst_ctl, .fixing, .time_known,
        .last_3d_alt, .alt_used, .sig_lock, .sig_level, .sig_used, .sol_valid, .pdop_3d, .dop_2d, .fix_sel,
        .fix_dec, .addr, .wdata, .wr, .rd, .rdata);
    rcd_host_model u_host (.clk, .srst, .rx_ready, .slow, .rx);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // collect report trail and event pulses
    always @(posedge clk) begin
        if (rpt.valid) rs <= {rs[17:0], rpt.id, rpt.nine_byte};
        if (init_pos.valid) pos_seen <= init_pos;
        if (time_set.valid) time_seen <= time_set;
        if (rst_ctl != 4'h0) rst_seen <= rst_ctl;
        if (init_pos.valid || time_set.valid || rst_ctl != 4'h0) ev <= ev + 1;
    end
    task chk(input string n, input logic [127:0] s, input logic [127:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task go(input logic [7:0] c, input logic [3:0] n, input logic [95:0] p);
        rs = 27'h0;
        ev = 0;
        u_host.put(c, n, p);
        for (k = 0; k < 300 && (u_host.q.size() > 0 || rx.valid); k++) begin
            @(posedge clk);
            #1;
        end
        if (k == 300) err_count++; // stuck packet counts as a mismatch
        repeat (8) @(posedge clk);
        #1;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, e);
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {srst, fixing, time_known, sol_valid, wr, rd, slow} = 7'h40;
        {wdata, pdop_3d, dop_2d, addr, sig_level} = '0;
        {rs, ev, err_count, checks_done} = '0;
        sig_lock = 8'h01;
        last_3d_alt = 32'haaaa5555;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("startup", rs, 27'h2291896);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h10, 32'h3);
        rd_chk(8'h04, 32'h3);
        rd_chk(8'h08, 32'h78);
        rd_chk(8'h0c, 32'h3c);
        rd_chk(8'h40, 32'h0);
        wr_reg(8'h14, 32'h1);
        rd_chk(8'h14, 32'h0);
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            go(rows[i][38:31], rows[i][30:27], 96'h0);
            chk("reports", rs, rows[i][26:0]);
            chk("events", ev, 0);
        end
        go(8'h2a, 4'h4, {32'h12345678, 64'h0});
        chk("alt set", rs, 27'h095);
        rd_chk(8'h14, 32'h12345678);
        wr_reg(8'h00, 32'h1);
        rd_chk(8'h18, 32'h12345678);
        go(8'h2a, 4'h1, {8'hff, 88'h0});
        rd_chk(8'h18, 32'haaaa5555);
        go(8'h23, 4'hc, 96'h11111111_22222222_33333333);
        chk("xyz", pos_seen, {96'h11111111_22222222_33333333, 2'b01});
        go(8'h2b, 4'hc, 96'h44444444_55555555_66666666);
        chk("lla", pos_seen, {96'h44444444_55555555_66666666, 2'b11});
        fixing <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            go(i ? 8'h2b : 8'h23, 4'hc, 96'h1);
            chk("fixing", {rs, ev}, 0);
        end
        go(8'h2e, 4'h6, {32'h40a00000, 16'h0801, 48'h0});
        chk("time", {rs, time_seen}, {27'h09c, 32'h40a00000, 16'h0801, 1'b1});
        time_known <= 1'b1;
        go(8'h2e, 4'h6, 96'h0);
        chk("time known", {rs, ev}, {27'h09c, 32'h0});
        for (int i = 0; i < 7; i++) begin
            wr_reg(8'h00, {30'h0, fx[i][19:18]});
            @(posedge clk);
            sol_valid <= 1'b1;
            pdop_3d <= fx[i][17:10];
            dop_2d <= fx[i][9:2];
            @(posedge clk);
            sol_valid <= 1'b0;
            #1;
            chk("fix", {fix_dec, fix_sel}, {1'b1, fx[i][1:0]});
        end
        // mask 3: admitted at 4, kept down to 2
        for (int i = 0; i < 4; i++) begin
            sig_level[0] <= 8'h3 + (i == 1) - (i > 1) - (i > 2);
            repeat (2) @(posedge clk);
            #1;
            chk("sig used", sig_used, {7'h0, i == 1 || i == 2});
        end
        wr_reg(8'h04, 32'h5);
        for (int i = 0; i < 3; i++) begin
            go(rr[i][23:16], rr[i][15:12], {rr[i][11:4], 88'h0});
            chk("reset kind", {rst_seen, rs}, {rr[i][3:0], 27'h2291896});
        end
        rd_chk(8'h04, 32'h3);
        // mid-run reset: defaults back, start-up reports again
        wr_reg(8'h08, 32'h10);
        rs = 27'h0;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("restart", rs, 27'h2291896);
        rd_chk(8'h08, 32'h78);
        close_out;
    end
    // watchdog against a hang
    initial begin
        #80000;
        err_count++;
        close_out;
    end
endmodule
